// [hw/cbt_bit_timing_config.sv]
// can bit timing configuration register, decode, wake path and bus line sampler
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module cbt_bit_timing_config (
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire cbt_pkg::cbt_axi_req_t axi_req,
	output cbt_pkg::cbt_axi_rsp_t      axi_rsp,
	input  wire logic                  bus_rx_raw,
	input  wire logic                  bus_rx_filtered,
	input  wire logic                  sample_point,
	output cbt_pkg::cbt_timing_t       timing,
	output logic                       wake_line,
	output logic                       sampled_bit,
	output logic                       sampled_valid
);
	import cbt_pkg::*;

	function automatic logic [3:0] quanta(input logic [2:0] code);
		quanta = {1'b0, code} + 4'h1;
	endfunction

	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	logic [15:0] can_bit_timing_second;
	logic        aw_full;
	logic        w_full;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic [2:0]  rx_hist;

	// bus handshakes and decode
	wire         aw_taken   = axi_req.awvalid & axi_rsp.awready;
	wire         w_taken    = axi_req.wvalid & axi_rsp.wready;
	wire         ar_taken   = axi_req.arvalid & axi_rsp.arready;
	wire         do_write   = aw_full & w_full & ~axi_rsp.bvalid;
	wire         wr_hit     = (aw_addr == CBT_OFS_CFG);
	wire         rd_cfg     = (axi_req.araddr == CBT_OFS_CFG);
	wire         rd_sts     = (axi_req.araddr == CBT_OFS_STATUS);
	wire         next_aw_full = aw_full ? ~do_write : aw_taken;
	wire         next_w_full  = w_full ? ~do_write : w_taken;
	wire         next_rvalid  = ar_taken | (axi_rsp.rvalid & ~axi_req.rready);
	wire         next_bvalid  = do_write | (axi_rsp.bvalid & ~axi_req.bready);
	wire [15:0]  byte_mask  = {{8{w_strb[1]}}, {8{w_strb[0]}}} & CBT_CFG_MASK;
	wire [15:0]  next_cfg   = (can_bit_timing_second & ~byte_mask) | (w_data[15:0] & byte_mask);

	// field decode
	wire [2:0]   ph2_code   = can_bit_timing_second[CBT_PH2_LSB +: CBT_FIELD_W];
	wire [2:0]   ph1_code   = can_bit_timing_second[CBT_PH1_LSB +: CBT_FIELD_W];
	wire [2:0]   prop_code  = can_bit_timing_second[CBT_PROP_LSB +: CBT_FIELD_W];
	wire         ph2_own    = can_bit_timing_second[CBT_BIT_PH2SEL];
	wire         triple_sel = can_bit_timing_second[CBT_BIT_TRIPLE];
	wire         wake_sel   = can_bit_timing_second[CBT_BIT_WAKE];
	wire [3:0]   ph1_q      = quanta(ph1_code); // [R05]
	wire [3:0]   ph2_own_q  = quanta(ph2_code); // [R02]
	wire [3:0]   ph2_der_q  = (ph1_q > CBT_INFO_PROC_QUANTA) ? ph1_q : CBT_INFO_PROC_QUANTA;
	wire [3:0]   ph2_q      = ph2_own ? ph2_own_q : ph2_der_q; // [R03]
	wire [3:0]   prop_q     = quanta(prop_code); // [R06]
	wire         next_wake  = wake_sel ? bus_rx_filtered : bus_rx_raw; // [R01]
	wire [2:0]   smp_set    = {rx_hist[1:0], bus_rx_raw};
	wire         next_smp   = triple_sel ? majority(smp_set) : bus_rx_raw; // [R04]

	wire [31:0]  sts_word   = {18'h0_0000, wake_sel, triple_sel, ph2_q, ph1_q, prop_q};
	wire [31:0]  rd_word    = rd_cfg ? {16'h0000, can_bit_timing_second} :
	                          (rd_sts ? sts_word : 32'h0000_0000);

	always_ff @(posedge mclk) begin
		if (srst) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			axi_rsp <= '0;
		end else begin
			aw_full         <= next_aw_full;
			w_full          <= next_w_full;
			axi_rsp.awready <= ~next_aw_full;
			axi_rsp.wready  <= ~next_w_full;
			axi_rsp.bvalid  <= next_bvalid;
			axi_rsp.arready <= ~next_rvalid;
			axi_rsp.rvalid  <= next_rvalid;
			if (do_write) begin
				axi_rsp.bresp <= wr_hit ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
			end
			if (ar_taken) begin
				axi_rsp.rdata <= rd_word;
				axi_rsp.rresp <= (rd_cfg | rd_sts) ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (aw_taken) begin
			aw_addr <= axi_req.awaddr;
		end
		if (w_taken) begin
			w_data <= axi_req.wdata;
			w_strb <= axi_req.wstrb;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			can_bit_timing_second <= CBT_CFG_RESET;
		end else if (do_write && wr_hit) begin
			can_bit_timing_second <= next_cfg;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			timing        <= '0;
			wake_line     <= 1'b0;
			rx_hist       <= '0;
			sampled_bit   <= 1'b0;
			sampled_valid <= 1'b0;
		end else begin
			timing.prop_quanta          <= prop_q;
			timing.phase_one_quanta     <= ph1_q;
			timing.phase_two_quanta     <= ph2_q;
			timing.triple_sample_select <= triple_sel;
			timing.wake_filter_select   <= wake_sel;
			wake_line                   <= next_wake;
			rx_hist                     <= {rx_hist[1:0], bus_rx_raw};
			sampled_valid               <= sample_point;
			if (sample_point) begin
				sampled_bit <= next_smp;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	AST_WAKE_PATH: assert property ( // [R01]
		!srst |=> wake_line == ($past(wake_sel) ? $past(bus_rx_filtered) : $past(bus_rx_raw)))
		else $error("wake line not routed by filter select");
	AST_PH2_OWN: assert property ( // [R02]
		ph2_own |=> timing.phase_two_quanta == {1'b0, $past(ph2_code)} + 4'h1)
		else $error("phase two length is not code plus one");
	AST_PH2_DERIVED: assert property ( // [R03]
		!srst && !ph2_own && ph1_code == 3'h0
		|=> timing.phase_two_quanta == CBT_INFO_PROC_QUANTA)
		else $error("derived phase two below processing time");
	AST_PH2_FOLLOW: assert property ( // [R03]
		!ph2_own && ph1_code == 3'h7 |=> timing.phase_two_quanta == 4'h8)
		else $error("derived phase two not following phase one");
	AST_SAMPLE_TRIPLE: assert property ( // [R04]
		sample_point && triple_sel && $past(bus_rx_raw, 2) == $past(bus_rx_raw, 1)
		|=> sampled_bit == $past(bus_rx_raw, 2))
		else $error("majority sample wrong");
	AST_SAMPLE_SINGLE: assert property ( // [R04]
		sample_point && !triple_sel |=> sampled_valid && sampled_bit == $past(bus_rx_raw))
		else $error("single sample wrong");
	AST_PH1_LEN: assert property ( // [R05]
		!srst |=> timing.phase_one_quanta == {1'b0, $past(ph1_code)} + 4'h1)
		else $error("phase one length is not code plus one");
	AST_PROP_LEN: assert property ( // [R06]
		!srst |=> timing.prop_quanta == {1'b0, $past(prop_code)} + 4'h1)
		else $error("propagation length is not code plus one");
	AST_WRITE_RESP: assert property (
		aw_taken && w_taken && !axi_rsp.bvalid |=> ##1 axi_rsp.bvalid)
		else $error("write response missing");
	AST_READ_RESP: assert property (
		ar_taken |=> axi_rsp.rvalid && !axi_rsp.arready)
		else $error("read response missing");

	// selects reach the timing outputs one cycle late
	AST_TIMING_WAKE_SEL: assert property ( // [R01]
		!srst |=> timing.wake_filter_select == $past(wake_sel))
		else $error("wake filter select not passed to timing");
	AST_TIMING_TRIPLE_SEL: assert property ( // [R04]
		!srst |=> timing.triple_sample_select == $past(triple_sel))
		else $error("triple sample select not passed to timing");

	// end points of the phase two own code, derived phase two equal to phase one, top code of phase one and propagation
	AST_PH2_OWN_MAX: assert property ( // [R02]
		!srst && ph2_own && ph2_code == 3'h7 |=> timing.phase_two_quanta == 4'h8)
		else $error("phase two code seven is not eight quanta");
	AST_PH2_OWN_MIN: assert property ( // [R02]
		!srst && ph2_own && ph2_code == 3'h0 |=> timing.phase_two_quanta == 4'h1)
		else $error("phase two code zero is not one quantum");
	AST_PH2_DER_EQUAL: assert property ( // [R03]
		!srst && !ph2_own && ph1_code != 3'h0
		|=> timing.phase_two_quanta == timing.phase_one_quanta)
		else $error("derived phase two differs from phase one");
	AST_PH1_MAX: assert property ( // [R05]
		!srst && ph1_code == 3'h7 |=> timing.phase_one_quanta == 4'h8)
		else $error("phase one code seven is not eight quanta");
	AST_PROP_MAX: assert property ( // [R06]
		!srst && prop_code == 3'h7 |=> timing.prop_quanta == 4'h8)
		else $error("propagation code seven is not eight quanta");

	// sampler output is a pulse plus a held level
	AST_VALID_PULSE: assert property ( // [R04]
		!srst |=> sampled_valid == $past(sample_point))
		else $error("sampled valid does not follow sample point");
	AST_SAMPLE_HOLD: assert property ( // [R04]
		!srst && !sample_point |=> $stable(sampled_bit))
		else $error("sampled bit moved without a sample point");

	// bus answers stand until taken, refused writes leave the register alone
	AST_BRESP_HOLD: assert property (
		axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped before bready");
	AST_RDATA_HOLD: assert property (
		axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped before rready");
	AST_BAD_WRITE_IGNORED: assert property (
		do_write && !wr_hit |=> $stable(can_bit_timing_second))
		else $error("unmapped write changed the register");
	AST_READY_LOW_FULL: assert property (
		!srst |-> (!aw_full || !axi_rsp.awready) && (!w_full || !axi_rsp.wready))
		else $error("ready high while a write is held");
	AST_RESERVED_READ_ZERO: assert property (
		!srst && ar_taken && rd_cfg
		|=> (axi_rsp.rdata[15:0] & ~CBT_CFG_MASK) == 16'h0000)
		else $error("reserved bits read as nonzero");

	COV_TRIPLE: cover property (sample_point && triple_sel ##1 sampled_valid);
	COV_DERIVED: cover property (do_write && wr_hit && !next_cfg[CBT_BIT_PH2SEL]);
	COV_WAKE_FILT: cover property (wake_sel && bus_rx_filtered != bus_rx_raw);
	COV_BAD_ADDR: cover property (axi_rsp.rvalid && axi_rsp.rresp == CBT_RESP_SLVERR);
	COV_OWN_PH2: cover property (do_write && wr_hit && next_cfg[CBT_BIT_PH2SEL]);
endmodule

// [hw/cbt_pkg.sv]
// shared constants and carrier types for the can bit timing configuration block
// Functional notes
// R01: wake filter select routes wake line through filter
// R02: phase two length equals code plus one
// R03: phase two own length, else max(phase one, processing)
// R04: triple sample select takes three-sample majority
// R05: phase one length equals code plus one
// R06: propagation length equals code plus one
package cbt_pkg;
	localparam logic [31:0] CBT_OFS_CFG    = 32'h0000_0000;
	localparam logic [31:0] CBT_OFS_STATUS = 32'h0000_0004;
	localparam logic [15:0] CBT_CFG_RESET  = 16'h0000;
	localparam logic [15:0] CBT_CFG_MASK   = 16'h47FF;
	localparam int          CBT_BIT_WAKE   = 14;
	localparam int          CBT_PH2_LSB    = 8;
	localparam int          CBT_BIT_PH2SEL = 7;
	localparam int          CBT_BIT_TRIPLE = 6;
	localparam int          CBT_PH1_LSB    = 3;
	localparam int          CBT_PROP_LSB   = 0;
	localparam int          CBT_FIELD_W    = 3;
	localparam int          CBT_STS_PH1    = 4;
	localparam int          CBT_STS_PH2    = 8;
	localparam int          CBT_STS_TRIPLE = 12;
	localparam int          CBT_STS_WAKE   = 13;
	localparam logic [3:0]  CBT_INFO_PROC_QUANTA = 4'h2;
	localparam logic [1:0]  CBT_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  CBT_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} cbt_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cbt_axi_rsp_t;

	typedef struct packed {
		logic [3:0] prop_quanta;
		logic [3:0] phase_one_quanta;
		logic [3:0] phase_two_quanta;
		logic       triple_sample_select;
		logic       wake_filter_select;
	} cbt_timing_t;
endpackage

// [verification/cbt_bit_timing_config_tb.sv]
// testbench for the can bit timing configuration block
`timescale 1ns/100ps
module cbt_bit_timing_config_tb;
	import cbt_pkg::*;
	logic         mclk = 0, srst = 1, go = 0, filt = 0, s, raw, flt, sp, wk, sb, sv;
	logic [2:0]   pat = 3'h0, c;
	logic [31:0]  d;
	logic [1:0]   r;
	cbt_axi_req_t req = '0;
	cbt_axi_rsp_t rsp;
	cbt_timing_t  tm;
	int           error_cnt = 0, n_tests = 0, k;
	initial forever #2.5 mclk = ~mclk;
	cbt_bus_node_model i_cbt_bus_node_model(.mclk(mclk), .go(go), .pat(pat), .filt(filt),
		.bus_rx_raw(raw), .bus_rx_filtered(flt), .sample_point(sp));
	cbt_bit_timing_config i_cbt_bit_timing_config(.mclk(mclk), .srst(srst), .axi_req(req),
		.axi_rsp(rsp), .bus_rx_raw(raw), .bus_rx_filtered(flt), .sample_point(sp),
		.timing(tm), .wake_line(wk), .sampled_bit(sb), .sampled_valid(sv));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] v);
		logic pa, pw;
		pa = 1;
		pw = 1;
		@(posedge mclk);
		req.awaddr <= a;
		req.wdata <= {16'h0000, v};
		req.wstrb <= 4'hF;
		req.awvalid <= 1;
		req.wvalid <= 1;
		req.bready <= 1;
		while (pa || pw) begin
			@(posedge mclk);
			if (rsp.awready === 1) pa = 0;
			if (rsp.wready === 1) pw = 0;
			req.awvalid <= pa;
			req.wvalid <= pw;
		end
		while (rsp.bvalid !== 1) @(posedge mclk);
		r = rsp.bresp;
		req.bready <= 0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge mclk);
		req.araddr <= a;
		req.arvalid <= 1;
		req.rready <= 1;
		do @(posedge mclk); while (rsp.arready !== 1);
		req.arvalid <= 0;
		do @(posedge mclk); while (rsp.rvalid !== 1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 0;
	endtask
	function automatic logic [31:0] ex(input logic [2:0] c2, c1, p, input logic s, t, w);
		logic [3:0] q1, q2;
		q1 = {1'b0, c1} + 4'h1;
		q2 = (q1 > CBT_INFO_PROC_QUANTA) ? q1 : CBT_INFO_PROC_QUANTA;
		return {18'h0, {1'b0, p} + 4'h1, q1, s ? {1'b0, c2} + 4'h1 : q2, t, w};
	endfunction
	initial begin
		repeat (2) @(posedge mclk);
		srst <= 0;
		@(posedge mclk);
		@(negedge mclk);
		chk("timing reset", {18'h0, 4'h1, 4'h1, 4'h2, 2'b00}, tm);
		rd(CBT_OFS_CFG);
		chk("cfg reset", 32'h0, d);
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			c = i[3:1];
			s = i[0];
			wr(CBT_OFS_CFG, {1'b0, ~s, 3'b000, c, s, s, ~c, c});
			@(posedge mclk);
			chk("timing", ex(c, ~c, c, s, s, ~s), tm);
			rd(CBT_OFS_CFG);
			chk("cfg", {17'h0, ~s, 3'b000, c, s, s, ~c, c}, d);
		end
		$display("field test done");
		wr(CBT_OFS_CFG, 16'hFFFF);
		rd(CBT_OFS_CFG);
		chk("reserved", 32'h0000_47FF, d);
		rd(CBT_OFS_STATUS);
		chk("status", 32'h0000_3888, d);
		wr(32'h0000_0010, 16'h0000);
		chk("bresp", CBT_RESP_SLVERR, r);
		rd(32'h0000_0010);
		chk("bad rdata", 32'h0, d);
		chk("rresp", CBT_RESP_SLVERR, r);
		wr(CBT_OFS_STATUS, 16'h0000);
		chk("status bresp", CBT_RESP_SLVERR, r);
		repeat (3) @(posedge mclk);
		chk("wake filtered", 32'h0, wk);
		filt <= 1;
		repeat (3) @(posedge mclk);
		chk("wake filtered high", 32'h1, wk);
		filt <= 0;
		wr(CBT_OFS_CFG, 16'h07FF);
		repeat (3) @(posedge mclk);
		chk("wake raw", 32'h1, wk);
		$display("bus test done");
		for (int i = 0; i < 4; i++) begin
			s = i[1];
			wr(CBT_OFS_CFG, {9'h0, s, 6'h00});
			@(posedge mclk);
			pat <= i[0] ? 3'b110 : 3'b001;
			go <= 1;
			@(posedge mclk);
			go <= 0;
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (sv !== 1 && k < 10);
			chk("sampled", {30'h0, 1'b1, s ~^ i[0]}, {30'h0, sv, sb});
		end
		$display("sampler test done");
		tally_and_finish();
	end
	initial begin
		#50000;
		error_cnt++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule

// [verification/cbt_bus_node_model.sv]
// model of the other bus nodes: bus line levels and the sample point pulse
`timescale 1ns/100ps
module cbt_bus_node_model (
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic [2:0] pat,
	input  wire logic       filt,
	output logic            bus_rx_raw,
	output logic            bus_rx_filtered,
	output logic            sample_point
);
	logic [2:0] sh  = 3'h7;
	logic [1:0] cnt = 2'h0;
	// three bits a frame, sample point on the last; the line then steps to the inverse of the first bit and holds it
	always_ff @(posedge mclk) begin
		sample_point <= (cnt == 2'h2);
		if (go) begin
			sh <= pat;
			cnt <= 2'h3;
		end else if (cnt != 2'h0) begin
			sh <= {sh[1:0], ~sh[2]};
			cnt <= cnt - 2'h1;
		end
	end
	assign bus_rx_raw = sh[2];
	assign bus_rx_filtered = filt;
endmodule
